/* hw/plfl_loop_ctrl.sv */
// Fastlock, pin function, pump current, slip reduction and counter reset control of the RF and IF loops.
// How it works
// - Timeout 0 to 3: timed fastlock off; pin is general-purpose output for 0, 2 and 3.
// - Timeout 4 to 16383: timed fastlock on, pin shows fastlock.
// - Fastlock lasts twice the timeout value in comparison cycles.
// - Timeout 1: manual fastlock, all fastlock conditions forced, pin driven low.
// - General-purpose pin: code 0 floats, 2 drives low, 3 drives high.
// - Fastlock pump current is code plus one unit currents.
// - Slip reducer code 0 off; 1,2,3 divide sample rate by 2,4,16.
// - Quarter-rate bit divides RF lock detect events by four; IF untouched.
// - IF reset bit holds IF counters reset and floats IF pump.
// - RF reset bit holds RF counters reset and floats RF pump.
// - Any power-up forces a counter reset automatically.
// - RF float bit floats RF pump, counters keep running; default 0.
// - IF float bit floats IF pump, counters keep running; default 0.
`timescale 1ns/1ps
module plfl_loop_ctrl #(
  parameter int PWRUP_CYCLES = plfl_pkg::PWRUP_RST_CYCLES
) (
  input  wire logic                        i_ref_clk,               // System clock, 125 MHz.
  input  wire logic                        i_reset,                 // Synchronous reset, active high.
  input  wire logic                        i_reg_wr,                // Register word written, pulse.
  input  wire logic [plfl_pkg::WORD_W-1:0] i_reg_word,              // Register word, address in low nibble.
  input  wire logic                        i_freq_prog,             // New frequency programmed, pulse.
  input  wire logic                        i_power_up,              // Power-up by software or enable pin, pulse.
  input  wire logic                        i_rf_pd_event,           // RF comparison event, pulse.
  input  wire logic                        i_if_pd_event,           // IF comparison event, pulse.
  output      logic                        o_rf_fastlock_active,    // RF loop in fastlock state.
  output      logic [4:0]                  o_rf_fastlock_pump_mult, // Pump current in unit currents.
  output      logic                        o_slip_reducer_on,       // Slip reducer on.
  output      logic [2:0]                  o_slip_rate_shift,       // Sample rate divided by two to this.
  output      logic                        o_rf_fastlock_pin_out,   // Fastlock pin level.
  output      logic                        o_rf_fastlock_pin_oe,    // Fastlock pin drive enable, high drives.
  output      logic                        o_rf_ld_event,           // Event to RF lock detector, pulse.
  output      logic                        o_if_ld_event,           // Event to IF lock detector, pulse.
  output      logic                        o_rf_counter_reset,      // RF N and R counters held in reset.
  output      logic                        o_if_counter_reset,      // IF N and R counters held in reset.
  output      logic                        o_rf_pump_float,         // RF charge pump floated.
  output      logic                        o_if_pump_float          // IF charge pump floated.
);
  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [2:0] slip_shift(input logic [1:0] code);
    unique case (code)
      2'h0: slip_shift = 3'h0;
      2'h1: slip_shift = 3'h1;
      2'h2: slip_shift = 3'h2;
      2'h3: slip_shift = 3'h4;
    endcase
  endfunction

  function automatic logic [4:0] pump_mult(input logic [3:0] code);
    pump_mult = {1'b0, code} + 5'h01;
  endfunction

  // ----------------------------------------------------------------
  // Register words
  // ----------------------------------------------------------------
  logic [13:0] rf_fastlock_timeout_q;
  logic [3:0]  rf_fastlock_pump_current_q;
  logic [1:0]  cycle_slip_reducer_q;
  logic        lock_detect_quarter_rate_q;
  logic        rf_counter_reset_bit_q;
  logic        if_counter_reset_bit_q;
  logic        rf_pump_float_field_q;
  logic        if_pump_float_field_q;

  wire [3:0] wr_addr  = i_reg_word[plfl_pkg::ADDR_LSB +: plfl_pkg::ADDR_W];
  wire       wr_fast  = i_reg_wr && (wr_addr == plfl_pkg::ADDR_FASTLOCK);
  wire       wr_ctrl  = i_reg_wr && (wr_addr == plfl_pkg::ADDR_LOOP_CTRL);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rf_fastlock_timeout_q      <= plfl_pkg::TOC_RESET;
      rf_fastlock_pump_current_q <= plfl_pkg::CPF_RESET;
      cycle_slip_reducer_q       <= plfl_pkg::SLIP_RESET;
    end else if (wr_fast) begin
      rf_fastlock_timeout_q      <= i_reg_word[plfl_pkg::TOC_LSB +: plfl_pkg::TOC_W];
      rf_fastlock_pump_current_q <= i_reg_word[plfl_pkg::CPF_LSB +: plfl_pkg::CPF_W];
      cycle_slip_reducer_q       <= i_reg_word[plfl_pkg::SLIP_LSB +: plfl_pkg::SLIP_W];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      lock_detect_quarter_rate_q <= plfl_pkg::BIT_RESET;
      rf_counter_reset_bit_q     <= plfl_pkg::BIT_RESET;
      if_counter_reset_bit_q     <= plfl_pkg::BIT_RESET;
      rf_pump_float_field_q      <= plfl_pkg::BIT_RESET;
      if_pump_float_field_q      <= plfl_pkg::BIT_RESET;
    end else if (wr_ctrl) begin
      lock_detect_quarter_rate_q <= i_reg_word[plfl_pkg::QUARTER_BIT];
      rf_counter_reset_bit_q     <= i_reg_word[plfl_pkg::RF_HOLD_BIT];
      if_counter_reset_bit_q     <= i_reg_word[plfl_pkg::IF_HOLD_BIT];
      rf_pump_float_field_q      <= i_reg_word[plfl_pkg::RF_FLOAT_BIT];
      if_pump_float_field_q      <= i_reg_word[plfl_pkg::IF_FLOAT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Fastlock mode and timeout
  // ----------------------------------------------------------------
  wire timed_mode  = (rf_fastlock_timeout_q >= plfl_pkg::TOC_TIMED_MIN);
  wire manual_mode = (rf_fastlock_timeout_q == plfl_pkg::TOC_MANUAL);
  wire timer_busy;
  wire [plfl_pkg::FL_CNT_W-1:0] timer_load = {rf_fastlock_timeout_q, 1'b0};

  // Leaving timed mode kills a running period so a general-purpose pin code takes effect at once.
  plfl_timeout #(
    .CNT_W (plfl_pkg::FL_CNT_W)
  ) u_timeout (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_start   (i_freq_prog && timed_mode),
    .i_load    (timer_load),
    .i_tick    (i_rf_pd_event),
    .i_abort   (!timed_mode),
    .o_busy    (timer_busy)
  );

  wire fl_active = manual_mode || (timed_mode && timer_busy);

  // Pin in general-purpose mode follows the code; in timed mode it is pulled low only while fastlock runs.
  wire pin_oe_d  = manual_mode ? 1'b1 :
                   timed_mode  ? timer_busy :
                   (rf_fastlock_timeout_q != plfl_pkg::TOC_GP_FLOAT);
  wire pin_out_d = (!timed_mode && !manual_mode) &&
                   (rf_fastlock_timeout_q == plfl_pkg::TOC_GP_HIGH);

  // ----------------------------------------------------------------
  // Lock detect event divider
  // ----------------------------------------------------------------
  logic [plfl_pkg::LD_DIV_W-1:0] ld_div_q;
  wire  ld_wrap = (ld_div_q == plfl_pkg::LD_DIV_W'(plfl_pkg::LD_DIV - 1));
  wire  rf_ld_d = i_rf_pd_event && (!lock_detect_quarter_rate_q || ld_wrap);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ld_div_q <= '0;
    end else if (i_rf_pd_event) begin
      ld_div_q <= ld_div_q + plfl_pkg::LD_DIV_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Power-up counter reset
  // ----------------------------------------------------------------
  logic [3:0] pwrup_cnt_q;
  wire        pwrup_rst = (pwrup_cnt_q != 4'h0);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pwrup_cnt_q <= 4'h0;
    end else if (i_power_up) begin
      pwrup_cnt_q <= 4'(PWRUP_CYCLES);
    end else if (pwrup_rst) begin
      pwrup_cnt_q <= pwrup_cnt_q - 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Counter hold and pump float
  // ----------------------------------------------------------------
  // A counter reset floats the pump as well; the float bits alone leave the counters counting.
  wire rf_hold_d  = rf_counter_reset_bit_q || pwrup_rst;
  wire if_hold_d  = if_counter_reset_bit_q || pwrup_rst;
  wire rf_float_d = rf_hold_d || rf_pump_float_field_q;
  wire if_float_d = if_hold_d || if_pump_float_field_q;

  // ----------------------------------------------------------------
  // Pump current and slip reducer decode
  // ----------------------------------------------------------------
  wire [4:0] pump_mult_d  = pump_mult(rf_fastlock_pump_current_q);
  wire [2:0] slip_shift_d = slip_shift(cycle_slip_reducer_q);
  wire       slip_on_d    = (slip_shift(cycle_slip_reducer_q) != 3'h0);

  // ----------------------------------------------------------------
  // Fastlock and decode outputs
  // ----------------------------------------------------------------
  // Fastlock state and pin drive leave through flops so the pin never glitches on a register write.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rf_fastlock_active  <= 1'b0;
      o_rf_fastlock_pin_out <= 1'b0;
      o_rf_fastlock_pin_oe  <= 1'b0;
    end else begin
      o_rf_fastlock_active  <= fl_active;
      o_rf_fastlock_pin_out <= pin_out_d;
      o_rf_fastlock_pin_oe  <= pin_oe_d;
    end
  end

  // The settings behind these have their own reset, so the decoded values settle while reset is held.
  always_ff @(posedge i_ref_clk) begin
    o_rf_fastlock_pump_mult <= pump_mult_d;
    o_slip_reducer_on       <= slip_on_d;
    o_slip_rate_shift       <= slip_shift_d;
  end

  // ----------------------------------------------------------------
  // Event and loop reset outputs
  // ----------------------------------------------------------------
  // Lock detect events leave one cycle after the comparison event that caused them.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rf_ld_event <= 1'b0;
      o_if_ld_event <= 1'b0;
    end else begin
      o_rf_ld_event <= rf_ld_d;
      o_if_ld_event <= i_if_pd_event;
    end
  end

  // Counter hold and pump float leave together so the loop sees both change on one edge.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rf_counter_reset <= 1'b0;
      o_if_counter_reset <= 1'b0;
      o_rf_pump_float    <= 1'b0;
      o_if_pump_float    <= 1'b0;
    end else begin
      o_rf_counter_reset <= rf_hold_d;
      o_if_counter_reset <= if_hold_d;
      o_rf_pump_float    <= rf_float_d;
      o_if_pump_float    <= if_float_d;
    end
  end
endmodule

/* hw/plfl_pkg.sv */
// Package of register layout, field positions, reset values and timing counts for the loop control block.
package plfl_pkg;
  // ----------------------------------------------------------------
  // Register words and control-nibble addresses
  // ----------------------------------------------------------------
  localparam int          WORD_W          = 24;
  localparam int          ADDR_LSB        = 0;
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  ADDR_FASTLOCK   = 4'hD;
  localparam logic [3:0]  ADDR_LOOP_CTRL  = 4'hF;

  // ----------------------------------------------------------------
  // Fastlock word fields
  // ----------------------------------------------------------------
  localparam int          TOC_LSB         = 4;
  localparam int          TOC_W           = 14;
  localparam int          CPF_LSB         = 18;
  localparam int          CPF_W           = 4;
  localparam int          SLIP_LSB        = 22;
  localparam int          SLIP_W          = 2;
  localparam int          FL_CNT_W        = TOC_W + 1;

  // ----------------------------------------------------------------
  // Loop reset and lock detect control word fields
  // ----------------------------------------------------------------
  localparam int          RF_FLOAT_BIT    = 4;
  localparam int          IF_FLOAT_BIT    = 5;
  localparam int          RF_HOLD_BIT     = 6;
  localparam int          IF_HOLD_BIT     = 7;
  localparam int          QUARTER_BIT     = 13;

  // ----------------------------------------------------------------
  // Reset values and timeout codes
  // ----------------------------------------------------------------
  localparam logic [13:0] TOC_RESET       = 14'h0000;
  localparam logic [3:0]  CPF_RESET       = 4'h0;
  localparam logic [1:0]  SLIP_RESET      = 2'h0;
  localparam logic        BIT_RESET       = 1'b0;
  localparam logic [13:0] TOC_GP_FLOAT    = 14'h0000;
  localparam logic [13:0] TOC_MANUAL      = 14'h0001;
  localparam logic [13:0] TOC_GP_LOW      = 14'h0002;
  localparam logic [13:0] TOC_GP_HIGH     = 14'h0003;
  localparam logic [13:0] TOC_TIMED_MIN   = 14'h0004;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          PWRUP_RST_CYCLES = 4;
  localparam int          LD_DIV           = 4;
  localparam int          LD_DIV_W         = 2;
endpackage

/* hw/plfl_timeout.sv */
// Fastlock timeout counter clocked by comparison events.
`timescale 1ns/1ps
module plfl_timeout #(
  parameter int CNT_W = plfl_pkg::FL_CNT_W
) (
  input  wire logic             i_ref_clk,  // System clock.
  input  wire logic             i_reset,    // Synchronous reset, active high.
  input  wire logic             i_start,    // Load the count, one-cycle pulse.
  input  wire logic [CNT_W-1:0] i_load,     // Number of comparison events to stay busy.
  input  wire logic             i_tick,     // Comparison event, one-cycle pulse.
  input  wire logic             i_abort,    // Drop the count at once.
  output      logic             o_busy      // Count not yet expired.
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  wire              running = (cnt_q != '0);

  // A fresh start wins over a tick in the same cycle so the full period is kept.
  assign cnt_d = i_abort ? '0 :
                 i_start ? i_load :
                 (i_tick && running) ? cnt_q - CNT_W'(1) : cnt_q;
  assign o_busy = running;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

/* tb/plfl_loop_ctrl_asserts.sv */
// Concurrent checks on the loop control block ports.
`timescale 1ns/1ps
module plfl_loop_ctrl_asserts (
  input wire logic        i_ref_clk,             // Clock.
  input wire logic        i_reset,               // Reset.
  input wire logic        i_reg_wr,              // Write strobe.
  input wire logic [23:0] i_reg_word,            // Word.
  input wire logic        i_power_up,            // Power-up.
  input wire logic        o_rf_fastlock_active,  // Fastlock.
  input wire logic [4:0]  o_rf_fastlock_pump_mult, // Current.
  input wire logic        o_slip_reducer_on,     // Reducer on.
  input wire logic [2:0]  o_slip_rate_shift,     // Rate shift.
  input wire logic        o_rf_fastlock_pin_out, // Pin level.
  input wire logic        o_rf_fastlock_pin_oe,  // Pin drive.
  input wire logic        o_rf_counter_reset,    // RF reset.
  input wire logic        o_if_counter_reset,    // IF reset.
  input wire logic        o_rf_pump_float,       // RF float.
  input wire logic        o_if_pump_float        // IF float.
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // The bench holds the word after a write, so consequents may read it.
  wire fl_wr = i_reg_wr && i_reg_word[3:0] == plfl_pkg::ADDR_FASTLOCK;
  wire lc_wr = i_reg_wr && i_reg_word[3:0] == plfl_pkg::ADDR_LOOP_CTRL;
  pin_float_a: assert property (fl_wr && i_reg_word[17:4] == 14'h0000
    |-> ##[1:3] !o_rf_fastlock_pin_oe) else $error("Pin not floated.");
  manual_mode_a: assert property (fl_wr && i_reg_word[17:4] == 14'h0001
    |-> ##[1:3] o_rf_fastlock_active && o_rf_fastlock_pin_oe && !o_rf_fastlock_pin_out) else $error("Manual wrong.");
  pin_low_a: assert property (fl_wr && i_reg_word[17:4] == 14'h0002
    |-> ##[1:3] o_rf_fastlock_pin_oe && !o_rf_fastlock_pin_out) else $error("Pin not low.");
  pin_high_a: assert property (fl_wr && i_reg_word[17:4] == 14'h0003
    |-> ##[1:3] o_rf_fastlock_pin_oe && o_rf_fastlock_pin_out) else $error("Pin not high.");
  pump_mult_a: assert property (fl_wr
    |-> ##[1:3] o_rf_fastlock_pump_mult == {1'b0, i_reg_word[21:18]} + 5'h01) else $error("Pump current wrong.");
  slip_code_a: assert property (fl_wr |-> ##[1:3] o_slip_reducer_on == (i_reg_word[23:22] != 2'h0) &&
    o_slip_rate_shift == (i_reg_word[23:22] == 2'h3 ? 3'h4 : {1'b0, i_reg_word[23:22]})) else $error("Slip code wrong.");
  rf_reset_a: assert property (lc_wr && i_reg_word[6]
    |-> ##[1:3] o_rf_counter_reset && o_rf_pump_float) else $error("RF reset missing.");
  if_reset_a: assert property (lc_wr && i_reg_word[7]
    |-> ##[1:3] o_if_counter_reset && o_if_pump_float) else $error("IF reset missing.");
  rf_float_a: assert property (lc_wr && i_reg_word[7:4] == 4'h1
    |-> ##[1:3] o_rf_pump_float && !o_rf_counter_reset) else $error("RF float wrong.");
  if_float_a: assert property (lc_wr && i_reg_word[7:4] == 4'h2
    |-> ##[1:3] o_if_pump_float && !o_if_counter_reset) else $error("IF float wrong.");
  pwr_reset_a: assert property (i_power_up
    |-> ##[1:3] o_rf_counter_reset && o_if_counter_reset) else $error("Power-up reset missing.");
endmodule
bind plfl_loop_ctrl plfl_loop_ctrl_asserts u_asserts (
  .i_ref_clk               (i_ref_clk),
  .i_reset                 (i_reset),
  .i_reg_wr                (i_reg_wr),
  .i_reg_word              (i_reg_word),
  .i_power_up              (i_power_up),
  .o_rf_fastlock_active    (o_rf_fastlock_active),
  .o_rf_fastlock_pump_mult (o_rf_fastlock_pump_mult),
  .o_slip_reducer_on       (o_slip_reducer_on),
  .o_slip_rate_shift       (o_slip_rate_shift),
  .o_rf_fastlock_pin_out   (o_rf_fastlock_pin_out),
  .o_rf_fastlock_pin_oe    (o_rf_fastlock_pin_oe),
  .o_rf_counter_reset      (o_rf_counter_reset),
  .o_if_counter_reset      (o_if_counter_reset),
  .o_rf_pump_float         (o_rf_pump_float),
  .o_if_pump_float         (o_if_pump_float)
);

/* tb/plfl_pd_model.sv */
// Phase detector model giving RF and IF comparison events.
`timescale 1ns/1ps
module plfl_pd_model #(
  parameter int RF_DIV = 4, // Clocks per RF comparison.
  parameter int IF_DIV = 6  // Clocks per IF comparison.
) (
  input  wire logic i_ref_clk,  // Clock.
  input  wire logic i_reset,    // Reset.
  input  wire logic i_rf_hold,  // RF counters held.
  input  wire logic i_if_hold,  // IF counters held.
  output      logic o_rf_event, // RF comparison pulse.
  output      logic o_if_event  // IF comparison pulse.
);
  int rf_cnt = 0;
  int if_cnt = 0;
  // Held counters restart, so no event appears while the loop is in counter reset.
  always @(negedge i_ref_clk) begin
    rf_cnt <= (i_reset || i_rf_hold || rf_cnt == RF_DIV - 1) ? 0 : rf_cnt + 1;
    if_cnt <= (i_reset || i_if_hold || if_cnt == IF_DIV - 1) ? 0 : if_cnt + 1;
    o_rf_event <= !i_reset && !i_rf_hold && rf_cnt == RF_DIV - 1;
    o_if_event <= !i_reset && !i_if_hold && if_cnt == IF_DIV - 1;
  end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the loop control block.
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic [23:0] word = 24'h000000;
  logic        fp = 1'b0;
  logic        pu = 1'b0;
  logic        rfe, ife, act, cen, pout, poe, rld, ild, rcr, icr, rpf, ipf;
  logic [4:0]  mult;
  logic [2:0]  csh;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n, rl, il, re, ie;
  logic [2:0]  pin_tab [4] = '{3'h0, 3'h6, 3'h2, 3'h3};
  logic [3:0]  slip_tab [4] = '{4'h0, 4'h9, 4'hA, 4'hC};
  logic [3:0]  lc_tab [4] = '{4'h2, 4'h1, 4'hA, 4'h5};
  always #4 clk = ~clk;
  plfl_pd_model pd (.i_ref_clk(clk), .i_reset(rst), .i_rf_hold(rcr), .i_if_hold(icr), .o_rf_event(rfe),
    .o_if_event(ife));
  plfl_loop_ctrl DUT (.i_ref_clk(clk), .i_reset(rst), .i_reg_wr(wr), .i_reg_word(word), .i_freq_prog(fp),
    .i_power_up(pu), .i_rf_pd_event(rfe), .i_if_pd_event(ife), .o_rf_fastlock_active(act),
    .o_rf_fastlock_pump_mult(mult), .o_slip_reducer_on(cen), .o_slip_rate_shift(csh), .o_rf_fastlock_pin_out(pout),
    .o_rf_fastlock_pin_oe(poe), .o_rf_ld_event(rld), .o_if_ld_event(ild), .o_rf_counter_reset(rcr),
    .o_if_counter_reset(icr), .o_rf_pump_float(rpf), .o_if_pump_float(ipf));
  task automatic report_and_stop();
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The word is kept after the strobe so that the checker can read it.
  task automatic wr_word(input logic [23:0] w);
    @(negedge clk);
    wr = 1'b1;
    word = w;
    @(negedge clk);
    wr = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic pulse_count(input int len);
    {n, rl, il, re, ie} = 0;
    repeat (len) begin
      @(posedge clk);
      // Outputs have settled here and the model has not yet moved its events.
      #2;
      n += act && rfe;
      rl += rld;
      il += ild;
      re += rfe;
      ie += ife;
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk({rcr, icr, rpf, ipf}, 16'h0000);
    chk({act, poe, mult, cen, csh}, 16'h0010);
    for (int c = 0; c < 4; c++) begin
      wr_word({6'h00, c[13:0], 4'hD});
      chk({act, poe, poe & pout}, pin_tab[c]);
    end
    for (int c = 0; c < 16; c++) begin
      wr_word({c[1:0], c[3:0], 14'h0004, 4'hD});
      chk(mult, 16'(c + 1));
      chk({cen, csh}, slip_tab[c[1:0]]);
    end
    @(negedge clk);
    fp = 1'b1;
    @(negedge clk);
    fp = 1'b0;
    // A comparison event may count down on the very next edge, so counting starts there.
    fork
      pulse_count(200);
      begin
        @(negedge clk);
        chk({act, poe, pout}, 16'h0006);
      end
    join
    chk(16'(n), 16'h0008);
    chk({act, poe}, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr_word({10'h000, 1'b0, 5'h09, 4'h1 << c, 4'hF});
      chk({rcr, icr, rpf, ipf}, lc_tab[c]);
    end
    // The model compares well above the rate at which the quarter-rate bit is advised.
    wr_word({10'h000, 1'b1, 5'h09, 4'h0, 4'hF});
    pulse_count(128);
    chk(16'(rl >= re / 4 - 1 && rl <= re / 4 + 1), 16'h0001);
    chk(16'(il + 1 >= ie && il <= ie + 1), 16'h0001);
    @(negedge clk);
    pu = 1'b1;
    @(negedge clk);
    pu = 1'b0;
    @(negedge clk);
    chk({rcr, icr}, 16'h0003);
    repeat (8) @(negedge clk);
    chk({rcr, icr, rpf, ipf}, 16'h0000);
    report_and_stop();
  end
endmodule
